// ### rtl/console_control_status.sv
// console switch handling, restart sequencing and status lamp logic
`timescale 1ns/1ps
`default_nettype none
module console_control_status #(
  parameter int NCH = console_pkg::N_CHAN
) (
  input  wire logic           core_clk_i,
  input  wire logic           rst_i,
  // wishbone classic slave
  input  wire logic           wb_cyc_i,
  input  wire logic           wb_stb_i,
  input  wire logic           wb_we_i,
  input  wire logic [3:0]     wb_adr_i,
  input  wire logic [3:0]     wb_sel_i,
  input  wire logic [31:0]    wb_dat_i,
  output logic      [31:0]    wb_dat_o,
  output logic                wb_ack_o,
  // console switches
  input  wire logic [2:0]     sel_jump_sw_i,
  input  wire logic           man_int_sw_i,
  input  wire logic           eor_sw_i,
  input  wire logic           restart_sw_i,
  input  wire logic           sys_active_sw_i,
  input  wire logic           maint_mode_sw_i,
  input  wire logic [2:0]     equip_num_sw_i,
  input  wire logic           tw_power_sw_i,
  input  wire logic           fake_reply_sw_i,
  // processor and channel conditions
  input  wire logic           cpu_running_i,
  input  wire logic           cpu_stopped_i,
  input  wire logic [14:0]    p_upper_i,
  input  wire logic           int_active_i,
  input  wire logic           int_mode_i,
  input  wire logic [NCH-1:0] ch_active_i,
  input  wire logic [NCH-1:0] ch_parity_err_i,
  input  wire logic           tw_connect_i,
  input  wire logic [11:0]    connect_equipment_code_i,
  input  wire logic           tw_read_i,
  input  wire logic           tw_write_i,
  input  wire logic           tw_data_i,
  input  wire logic           fx_valid_i,
  input  wire logic [48:0]    fx_mag_i,
  input  wire logic           fp_valid_i,
  input  wire logic [12:0]    fp_exp_i,
  input  wire logic           sh_valid_i,
  input  wire logic           sh_double_i,
  input  wire logic [7:0]     sh_count_i,
  input  wire logic           dv_valid_i,
  input  wire logic [48:0]    dv_quot_mag_i,
  input  wire logic           dv_zero_i,
  input  wire logic           instr_par_err_i,
  input  wire logic           oper_par_err_i,
  input  wire logic           cyc_fetch_i,
  input  wire logic           cyc_upper_i,
  input  wire logic           cyc_lower_i,
  input  wire logic           full_word_i,
  input  wire logic           cyc_execute_i,
  input  wire logic           cyc_operand_i,
  input  wire logic           cyc_extended_i,
  input  wire logic           jump_pending_met_i,
  // actions
  output logic      [2:0]     sel_jump_cond_o,
  output logic      [2:0]     sel_jump_lamp_o,
  output logic                man_int_req_o,
  output logic                eor_o,
  output logic                tw_reply_o,
  output logic                tw_selected_o,
  output logic                cpu_halt_o,
  output logic                internal_master_clear_o,
  output logic                outward_master_clear_o,
  output logic                clear_int_active_o,
  output logic                return_jump_o,
  output logic      [14:0]    return_jump_addr_o,
  output logic      [14:0]    return_store_addr_o,
  output logic                sys_active_lamp_o,
  // lamps
  output logic      [NCH-1:0] ch_active_lamp_o,
  output logic      [NCH-1:0] ch_parity_lamp_o,
  output logic                running_lamp_o,
  output logic                prog_stop_lamp_o,
  output logic                int_active_lamp_o,
  output logic                int_mode_lamp_o,
  output logic                arith_ovf_lamp_o,
  output logic                exp_ovf_lamp_o,
  output logic                exp_unf_lamp_o,
  output logic                shift_fault_lamp_o,
  output logic                divide_fault_lamp_o,
  output logic                instr_par_lamp_o,
  output logic                oper_par_lamp_o,
  output logic                fetch_lamp_o,
  output logic                upper_lamp_o,
  output logic                lower_lamp_o,
  output logic                maint_lamp_o,
  output logic                execute_lamp_o,
  output logic                operand_lamp_o,
  output logic                extended_lamp_o,
  output logic                jump_cond_lamp_o,
  output logic                type_in_lamp_o
);
  localparam int NF = console_pkg::N_FAULT;

  typedef struct packed {
    console_pkg::restart_st_t rs;
    logic [14:0]    ret_addr;
    logic           rs_halt;
    logic           sys_off;
    logic           mc_int;
    logic           mc_ext;
    logic           clr_ia;
    logic           rjump;
    logic           mint;
    logic           eor;
    logic           reply;
    logic           conn;
    logic           mint_mask;
    logic [NF-1:0]  flt;
    logic [NCH-1:0] chact;
    logic [NCH-1:0] chpar;
    logic [2:0]     sj;
    logic           run;
    logic           stop;
    logic           ia;
    logic           im;
    logic [7:0]     cyc;
    logic           type_in;
    logic           ack;
    logic [31:0]    rdat;
  } state_t;

  state_t q;
  state_t d;

  logic [console_pkg::N_SW-1:0] sw_lvl;
  logic [console_pkg::N_SW-1:0] sw_rise;
  logic [console_pkg::N_SW-1:0] sw_fall;

  switch_sync #(
    .W (console_pkg::N_SW)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .sw_i       ({sys_active_sw_i, restart_sw_i, eor_sw_i, man_int_sw_i}),
    .lvl_o      (sw_lvl),
    .rise_o     (sw_rise),
    .fall_o     (sw_fall)
  );

  logic          sw_en;
  logic          tw_ok;
  logic [NF-1:0] flt_set;
  logic [NF-1:0] flt_clr;
  logic          bus_req;
  logic          bus_wr;
  logic [31:0]   stat_word;

  always_comb begin
    // lockout spares the system active, maintenance, typewriter power and equipment number switches
    sw_en   = sw_lvl[console_pkg::SW_SYSACT] | maint_mode_sw_i;
    tw_ok   = tw_power_sw_i;
    bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
    bus_wr  = bus_req & wb_we_i;

    flt_set = '0;
    flt_set[console_pkg::F_AOVF] = fx_valid_i & (|fx_mag_i[48:console_pkg::FX_BOUND_BIT]);
    flt_set[console_pkg::F_EOVF] = fp_valid_i & ($signed(fp_exp_i) > console_pkg::EXP_MAX);
    flt_set[console_pkg::F_EUNF] = fp_valid_i & ($signed(fp_exp_i) < -console_pkg::EXP_MAX);
    flt_set[console_pkg::F_SHFT] = sh_valid_i &
      (sh_double_i ? (sh_count_i > console_pkg::SHIFT_DBL_MAX)
                   : (sh_count_i > console_pkg::SHIFT_SGL_MAX));
    flt_set[console_pkg::F_DIV]  = dv_valid_i &
      ((|dv_quot_mag_i[48:console_pkg::FX_BOUND_BIT]) | dv_zero_i);
    flt_set[console_pkg::F_IPAR] = instr_par_err_i;
    flt_set[console_pkg::F_OPAR] = oper_par_err_i;

    flt_clr = '0;
    if (bus_wr && wb_adr_i == console_pkg::FCLR_OFS && wb_sel_i[0]) begin
      flt_clr = wb_dat_i[NF-1:0];
    end
    if (q.mc_int) begin
      flt_clr = '1;
    end

    stat_word = '0;
    stat_word[console_pkg::STAT_FLT_LSB +: NF]    = q.flt;
    stat_word[console_pkg::STAT_CHPAR_LSB +: NCH] = q.chpar;
    stat_word[console_pkg::STAT_CHACT_LSB +: NCH] = q.chact;
    stat_word[console_pkg::STAT_RUN_BIT]          = q.run;
    stat_word[console_pkg::STAT_STOP_BIT]         = q.stop;
    stat_word[console_pkg::STAT_RSTRT_BIT]        = (q.rs != console_pkg::RS_IDLE);
    stat_word[console_pkg::STAT_CONN_BIT]         = q.conn;
    stat_word[console_pkg::STAT_LOCK_BIT]         = ~sw_en;
  end

  always_comb begin
    d        = q;
    d.mc_int = 1'b0;
    d.mc_ext = 1'b0;
    d.clr_ia = 1'b0;
    d.rjump  = 1'b0;
    d.mint   = 1'b0;
    d.eor    = 1'b0;
    d.reply  = 1'b0;

    // system active transitions
    if (sw_rise[console_pkg::SW_SYSACT]) begin
      d.mc_int  = 1'b1;
      d.mc_ext  = 1'b1;
      d.sys_off = 1'b0;
    end else if (sw_fall[console_pkg::SW_SYSACT]) begin
      // only the processor halts; channels are not cleared here
      d.sys_off = 1'b1;
    end

    d.sj = sel_jump_sw_i & {3{sw_en}};

    if (sw_rise[console_pkg::SW_MINT] && sw_en) begin
      d.mint = q.mint_mask & int_active_i;
    end

    if (sw_rise[console_pkg::SW_EOR] && sw_en) begin
      d.eor = tw_ok & q.conn & tw_read_i & tw_data_i;
    end

    if (sw_en && fake_reply_sw_i && tw_ok && (tw_read_i || tw_write_i)) begin
      d.reply = 1'b1;
    end

    // a new connect code either selects or drops the typewriter
    if (tw_connect_i && tw_ok) begin
      d.conn = (connect_equipment_code_i[11:9] == equip_num_sw_i);
    end
    if (q.mc_ext || !tw_ok) begin
      d.conn = 1'b0;
    end

    case (q.rs)
      console_pkg::RS_IDLE: begin
        if (sw_rise[console_pkg::SW_RSTRT] && sw_en) begin
          d.rs_halt  = 1'b1;
          d.ret_addr = p_upper_i;
          d.rs       = console_pkg::RS_WSTOP;
        end
      end
      console_pkg::RS_WSTOP: begin
        // outward clear waits until the processor has stopped
        if (cpu_stopped_i) begin
          d.mc_ext = 1'b1;
          d.rs     = console_pkg::RS_CLRIA;
        end
      end
      console_pkg::RS_CLRIA: begin
        d.clr_ia = 1'b1;
        d.rs     = console_pkg::RS_JUMP;
      end
      console_pkg::RS_JUMP: begin
        d.rjump   = 1'b1;
        d.rs_halt = 1'b0;
        d.rs      = console_pkg::RS_IDLE;
      end
      default: begin
        d.rs      = console_pkg::RS_IDLE;
        d.rs_halt = 1'b0;
      end
    endcase

    // set wins over clear
    d.flt = (q.flt & ~flt_clr) | flt_set;

    for (int i = 0; i < NCH; i++) begin
      d.chact[i] = ch_active_i[i];
      d.chpar[i] = ch_parity_err_i[i];
    end

    // lamps sample every cycle regardless of run state
    d.run     = cpu_running_i | (|ch_active_i);
    d.stop    = cpu_stopped_i;
    d.ia      = int_active_i;
    d.im      = int_mode_i;
    d.cyc     = {cyc_fetch_i,
                 cyc_upper_i,
                 cyc_lower_i & ~full_word_i,
                 maint_mode_sw_i,
                 cyc_execute_i,
                 cyc_operand_i,
                 cyc_extended_i,
                 jump_pending_met_i};
    d.type_in = tw_ok & q.conn & tw_read_i;

    // wishbone: ack one cycle after the strobe, dropped the next
    d.ack = bus_req;
    if (bus_req) begin
      d.rdat = 32'h0000_0000;
      if (wb_adr_i == console_pkg::CTRL_OFS) begin
        d.rdat[console_pkg::CTRL_MINT_BIT] = q.mint_mask;
        if (wb_we_i && wb_sel_i[0]) begin
          d.mint_mask = wb_dat_i[console_pkg::CTRL_MINT_BIT];
        end
      end else if (wb_adr_i == console_pkg::STAT_OFS) begin
        d.rdat = stat_word;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q           <= '0;
      q.rs        <= console_pkg::RS_IDLE;
      q.mint_mask <= console_pkg::CTRL_RST[console_pkg::CTRL_MINT_BIT];
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o                = q.rdat;
  assign wb_ack_o                = q.ack;
  assign sel_jump_cond_o         = q.sj;
  assign sel_jump_lamp_o         = q.sj;
  assign man_int_req_o           = q.mint;
  assign eor_o                   = q.eor;
  assign tw_reply_o              = q.reply;
  assign tw_selected_o           = q.conn;
  assign cpu_halt_o              = q.rs_halt | q.sys_off;
  assign internal_master_clear_o = q.mc_int;
  assign outward_master_clear_o  = q.mc_ext;
  assign clear_int_active_o      = q.clr_ia;
  assign return_jump_o           = q.rjump;
  assign return_jump_addr_o      = console_pkg::RESTART_ADDR;
  assign return_store_addr_o     = q.ret_addr;
  assign sys_active_lamp_o       = sw_lvl[console_pkg::SW_SYSACT];
  assign ch_active_lamp_o        = q.chact;
  assign ch_parity_lamp_o        = q.chpar;
  assign running_lamp_o          = q.run;
  assign prog_stop_lamp_o        = q.stop;
  assign int_active_lamp_o       = q.ia;
  assign int_mode_lamp_o         = q.im;
  assign arith_ovf_lamp_o        = q.flt[console_pkg::F_AOVF];
  assign exp_ovf_lamp_o          = q.flt[console_pkg::F_EOVF];
  assign exp_unf_lamp_o          = q.flt[console_pkg::F_EUNF];
  assign shift_fault_lamp_o      = q.flt[console_pkg::F_SHFT];
  assign divide_fault_lamp_o     = q.flt[console_pkg::F_DIV];
  assign instr_par_lamp_o        = q.flt[console_pkg::F_IPAR];
  assign oper_par_lamp_o         = q.flt[console_pkg::F_OPAR];
  assign fetch_lamp_o            = q.cyc[7];
  assign upper_lamp_o            = q.cyc[6];
  assign lower_lamp_o            = q.cyc[5];
  assign maint_lamp_o            = q.cyc[4];
  assign execute_lamp_o          = q.cyc[3];
  assign operand_lamp_o          = q.cyc[2];
  assign extended_lamp_o         = q.cyc[1];
  assign jump_cond_lamp_o        = q.cyc[0];
  assign type_in_lamp_o          = q.type_in;
endmodule
`default_nettype wire

// ### inc/console_pkg.sv
// constants and types shared by the console control and status logic
package console_pkg;
  localparam logic [3:0]  CTRL_OFS        = 4'h0;
  localparam logic [3:0]  STAT_OFS        = 4'h4;
  localparam logic [3:0]  FCLR_OFS        = 4'h8;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  localparam int          CTRL_MINT_BIT   = 0;
  localparam int          STAT_FLT_LSB    = 0;
  localparam int          STAT_CHPAR_LSB  = 8;
  localparam int          STAT_CHACT_LSB  = 12;
  localparam int          STAT_RUN_BIT    = 16;
  localparam int          STAT_STOP_BIT   = 17;
  localparam int          STAT_RSTRT_BIT  = 18;
  localparam int          STAT_CONN_BIT   = 19;
  localparam int          STAT_LOCK_BIT   = 20;
  // fault vector positions
  localparam int          F_AOVF          = 0;
  localparam int          F_EOVF          = 1;
  localparam int          F_EUNF          = 2;
  localparam int          F_SHFT          = 3;
  localparam int          F_DIV           = 4;
  localparam int          F_IPAR          = 5;
  localparam int          F_OPAR          = 6;
  localparam int          N_FAULT         = 7;
  localparam int          N_CHAN          = 4;
  localparam int          FX_BOUND_BIT    = 47;
  localparam logic signed [12:0] EXP_MAX  = 13'sh03FF;
  localparam logic [7:0]  SHIFT_SGL_MAX   = 8'h30;
  localparam logic [7:0]  SHIFT_DBL_MAX   = 8'h60;
  localparam logic [14:0] RESTART_ADDR    = 15'h0000;
  localparam int          SW_MINT         = 0;
  localparam int          SW_EOR          = 1;
  localparam int          SW_RSTRT        = 2;
  localparam int          SW_SYSACT       = 3;
  localparam int          N_SW            = 4;
  typedef enum logic [1:0] {RS_IDLE, RS_WSTOP, RS_CLRIA, RS_JUMP} restart_st_t;
endpackage

// ### rtl/switch_sync.sv
// two-flop synchroniser with registered edge detect for console switches
`timescale 1ns/1ps
`default_nettype none
module switch_sync #(
  parameter int W = 4
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] sw_i,
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } sync_t;
  sync_t q;
  sync_t d;
  // s1 feeds only s2, so nothing samples a metastable level
  always_comb begin
    d      = q;
    d.s1   = sw_i;
    d.s2   = q.s1;
    d.s3   = q.s2;
    d.rise = q.s2 & ~q.s3;
    d.fall = ~q.s2 & q.s3;
  end
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign lvl_o  = q.s3;
  assign rise_o = q.rise;
  assign fall_o = q.fall;
endmodule
`default_nettype wire

// ### tb/console_control_status_assertions.sv
// property checks on the console control block ports
`timescale 1ns/1ps
`default_nettype none
module console_control_status_assertions #(
  parameter int NCH = 4
) (
  input wire logic           core_clk_i,
  input wire logic           rst_i,
  input wire logic [NCH-1:0] ch_active_i,
  input wire logic [NCH-1:0] ch_parity_err_i,
  input wire logic [NCH-1:0] ch_active_lamp_o,
  input wire logic [NCH-1:0] ch_parity_lamp_o,
  input wire logic           cpu_running_i,
  input wire logic           running_lamp_o,
  input wire logic           int_active_i,
  input wire logic           int_active_lamp_o,
  input wire logic           full_word_i,
  input wire logic           lower_lamp_o,
  input wire logic [2:0]     sel_jump_sw_i,
  input wire logic [2:0]     sel_jump_cond_o,
  input wire logic [2:0]     sel_jump_lamp_o,
  input wire logic           fx_valid_i,
  input wire logic [48:0]    fx_mag_i,
  input wire logic           arith_ovf_lamp_o,
  input wire logic           sh_valid_i,
  input wire logic           sh_double_i,
  input wire logic [7:0]     sh_count_i,
  input wire logic           shift_fault_lamp_o,
  input wire logic           man_int_req_o,
  input wire logic           cpu_halt_o,
  input wire logic           internal_master_clear_o,
  input wire logic           outward_master_clear_o,
  input wire logic           clear_int_active_o,
  input wire logic           return_jump_o
);
  // lamps judged once pre-reset inputs age out
  logic [1:0] live_q;
  logic       live;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      live_q <= 2'h0;
    end else if (live_q != 2'h3) begin
      live_q <= live_q + 2'h1;
    end
  end
  assign live = (live_q == 2'h3);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_restart_clear;
    outward_master_clear_o && cpu_halt_o && !internal_master_clear_o;
  endsequence
  sequence s_restart_tail;
    clear_int_active_o ##1 return_jump_o ##1 !cpu_halt_o;
  endsequence
  chan_lamps_a: assert property (
    live |-> {ch_active_lamp_o, ch_parity_lamp_o} == $past({ch_active_i, ch_parity_err_i}))
    else $error("channel lamps wrong");
  running_lamp_a: assert property (
    live && $past(cpu_running_i || (|ch_active_i)) |-> running_lamp_o)
    else $error("running lamp dark while busy");
  int_lamp_a: assert property (live |-> int_active_lamp_o == $past(int_active_i))
    else $error("interrupt enabled lamp wrong");
  full_word_a: assert property (live && $past(full_word_i) |-> !lower_lamp_o)
    else $error("lower lamp lit on a full word");
  jump_cond_a: assert property (
    live |-> sel_jump_lamp_o == sel_jump_cond_o && (sel_jump_cond_o & ~$past(sel_jump_sw_i)) == 3'h0)
    else $error("jump condition without switch");
  fix_ovf_a: assert property (fx_valid_i && fx_mag_i[48:47] != 2'h0 |=> arith_ovf_lamp_o)
    else $error("fixed overflow missed");
  shift_fault_a: assert property (
    sh_valid_i && sh_count_i > (sh_double_i ? 8'h60 : 8'h30) |=> shift_fault_lamp_o)
    else $error("shift fault missed");
  pulse_once_a: assert property (man_int_req_o |=> (!man_int_req_o) [*4])
    else $error("manual interrupt repeated");
  restart_order_a: assert property (s_restart_clear |=> s_restart_tail)
    else $error("restart steps out of order");
  both_clears_a: assert property (internal_master_clear_o |-> outward_master_clear_o)
    else $error("internal clear alone");
endmodule
bind console_control_status console_control_status_assertions #(.NCH(NCH)) u_chk (.*);
`default_nettype wire

// ### tb/console_panel_model.sv
// operator panel model: momentary switches held like a human press
`timescale 1ns/1ps
`default_nettype none
module console_panel_model #(
  parameter int HOLD = 6
) (
  input  wire logic       core_clk_i,
  input  wire logic [2:0] press_i,
  output logic      [2:0] mom_sw_o
);
  int cnt [3];
  // a press outlasts the synchroniser yet yields one action
  always @(posedge core_clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (press_i[i]) begin
        cnt[i] <= HOLD;
      end else if (cnt[i] > 0) begin
        cnt[i] <= cnt[i] - 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      mom_sw_o[i] = (cnt[i] > 0);
    end
  end
endmodule
`default_nettype wire

// ### tb/console_control_status_test.sv
// self-checking bench for the console control and status block
`timescale 1ns/1ps
`default_nettype none
module console_control_status_test;
  typedef struct packed {
    logic fxv; logic [48:0] fxm; logic fpv; logic [12:0] fpe; logic shv, shd; logic [7:0] shc;
    logic dvv; logic [48:0] dvq; logic dvz, ip, op;
  } fin_t;
  localparam logic [48:0] B47 = 49'h0_8000_0000_0000;
  localparam int NCH = 4;
  logic core_clk_i, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, int_active_i = 1'h0;
  logic sys_active_sw_i = 1'h0, maint_mode_sw_i = 1'h1, tw_power_sw_i = 1'h0, fake_reply_sw_i = 1'h0;
  logic cpu_stopped_i = 1'h0, tw_connect_i = 1'h0, tw_read_i = 1'h0, tw_write_i = 1'h0, tw_data_i = 1'h0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000, q, r;
  logic [2:0] equip_num_sw_i = 3'h0, press = 3'h0, mom;
  logic [14:0] p_upper_i = 15'h0000;
  logic [11:0] connect_equipment_code_i = 12'h000;
  logic [20:0] lv = 21'h00_0000, lvp;
  fin_t f = '0, fv;
  logic cpu_running_i, int_mode_i, cyc_fetch_i, cyc_upper_i, cyc_lower_i, full_word_i, cyc_execute_i;
  logic cyc_operand_i, cyc_extended_i, jump_pending_met_i, man_int_sw_i, eor_sw_i, restart_sw_i, m;
  logic [2:0] sel_jump_sw_i, sel_jump_cond_o, sel_jump_lamp_o;
  logic [NCH-1:0] ch_active_i, ch_parity_err_i, ch_active_lamp_o, ch_parity_lamp_o;
  logic fx_valid_i, fp_valid_i, sh_valid_i, sh_double_i, dv_valid_i, dv_zero_i, instr_par_err_i, oper_par_err_i;
  logic [48:0] fx_mag_i, dv_quot_mag_i;
  logic [12:0] fp_exp_i;
  logic [7:0] sh_count_i;
  logic [31:0] wb_dat_o;
  logic [14:0] return_jump_addr_o, return_store_addr_o;
  logic wb_ack_o, man_int_req_o, eor_o, tw_reply_o, tw_selected_o, cpu_halt_o, internal_master_clear_o;
  logic outward_master_clear_o, clear_int_active_o, return_jump_o, sys_active_lamp_o, running_lamp_o;
  logic prog_stop_lamp_o, int_active_lamp_o, int_mode_lamp_o, arith_ovf_lamp_o, exp_ovf_lamp_o, exp_unf_lamp_o;
  logic shift_fault_lamp_o, divide_fault_lamp_o, instr_par_lamp_o, oper_par_lamp_o, fetch_lamp_o, upper_lamp_o;
  logic lower_lamp_o, maint_lamp_o, execute_lamp_o, operand_lamp_o, extended_lamp_o, jump_cond_lamp_o;
  logic type_in_lamp_o;
  int seed = 32'hca55_4ec4, n, k, d, cyc_n = 0, n_mismatch = 0, samples_checked = 0;
  assign {cpu_running_i, sel_jump_sw_i, int_mode_i, ch_active_i, ch_parity_err_i, cyc_fetch_i, cyc_upper_i,
          cyc_execute_i, cyc_operand_i, cyc_extended_i, jump_pending_met_i, cyc_lower_i, full_word_i} = lv;
  assign {fx_valid_i, fx_mag_i, fp_valid_i, fp_exp_i, sh_valid_i, sh_double_i, sh_count_i, dv_valid_i,
          dv_quot_mag_i, dv_zero_i, instr_par_err_i, oper_par_err_i} = f;
  assign {restart_sw_i, eor_sw_i, man_int_sw_i} = mom;
  console_control_status dut (.*);
  console_panel_model u_panel (.core_clk_i(core_clk_i), .press_i(press), .mom_sw_o(mom));
  initial begin
    core_clk_i = 1'h0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  function automatic logic [6:0] fexp(fin_t a);
    logic signed [12:0] e;
    e = a.fpe;
    fexp = {a.op, a.ip, a.dvv & (a.dvq >= B47 | a.dvz), a.shv & (a.shc > (a.shd ? 8'h60 : 8'h30)),
            a.fpv & (e < -13'sh03ff), a.fpv & (e > 13'sh03ff), a.fxv & (a.fxm >= B47)};
  endfunction
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h got %h", nm, e, g);
    end
  endtask
  // one classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] dt, output logic [31:0] rd);
    int w;
    w = 0;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= dt;
    do begin
      @(posedge core_clk_i);
      w++;
    end while (wb_ack_o !== 1'h1 && w < 50);
    rd = wb_dat_o;
    chk("ack", 1'h1, wb_ack_o);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i <= 1'h0;
  endtask
  task automatic press_cnt(input int i, output int c);
    c = 0;
    @(posedge core_clk_i);
    press[i] <= 1'h1;
    @(posedge core_clk_i);
    press[i] <= 1'h0;
    repeat (14) begin
      @(posedge core_clk_i);
      if ((i == 0 ? man_int_req_o : eor_o) === 1'h1) c++;
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    lvp = lv;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'h0;
    wb(1'h0, 4'h0, 32'h0000_0000, q);
    chk("ctrl reset", 32'h0000_0000, q);
    wb(1'h1, 4'h0, 32'h0000_0001, q);
    wb(1'h0, 4'h0, 32'h0000_0000, q);
    chk("ctrl mask", 32'h0000_0001, q);
    wb(1'h1, 4'hc, 32'hffff_ffff, q);
    wb(1'h0, 4'hc, 32'h0000_0000, q);
    chk("unmapped", 32'h0000_0000, q);
    $display("test registers done");
    repeat (120) begin
      @(posedge core_clk_i);
      chk("lamps", {lvp[20] | |lvp[15:12], lvp[19:2], lvp[1] & ~lvp[0]}, {running_lamp_o, sel_jump_lamp_o,
          int_mode_lamp_o, ch_active_lamp_o, ch_parity_lamp_o, fetch_lamp_o, upper_lamp_o, execute_lamp_o,
          operand_lamp_o, extended_lamp_o, jump_cond_lamp_o, lower_lamp_o});
      lvp = lv;
      lv <= 21'($random(seed));
    end
    lv <= 21'h00_0000;
    $display("test lamps done");
    for (int i = 0; i < 30; i++) begin
      r = $random(seed);
      d = $unsigned($random(seed)) % 3 - 1;
      k = $unsigned($random(seed)) % 6;
      fv = '0;
      fv.fxm = B47 + 49'(d);
      fv.dvq = B47 + 49'(d);
      fv.dvz = r[10];
      fv.fpe = (r[9] ? 13'h1c00 : 13'h0400) + 13'(d);
      fv.shd = r[8];
      fv.shc = (fv.shd ? 8'h60 : 8'h30) + 8'(d);
      {fv.fxv, fv.fpv, fv.shv, fv.dvv, fv.ip, fv.op} = 6'h01 << k;
      @(posedge core_clk_i);
      f <= fv;
      @(posedge core_clk_i);
      f <= '0;
      @(posedge core_clk_i);
      chk("fault lamps", fexp(fv), {oper_par_lamp_o, instr_par_lamp_o, divide_fault_lamp_o, shift_fault_lamp_o,
          exp_unf_lamp_o, exp_ovf_lamp_o, arith_ovf_lamp_o});
      wb(1'h0, 4'h4, 32'h0000_0000, q);
      chk("fault status", fexp(fv), q[6:0]);
      wb(1'h1, 4'h8, 32'h0000_007f, q);
      wb(1'h0, 4'h4, 32'h0000_0000, q);
      chk("fault cleared", 7'h00, q[6:0]);
    end
    $display("test faults done");
    for (int c = 0; c < 8; c++) begin
      maint_mode_sw_i <= c[0];
      int_active_i <= c[1];
      wb(1'h1, 4'h0, {31'h0000_0000, c[2]}, q);
      repeat (5) @(posedge core_clk_i);
      press_cnt(0, n);
      chk("manual int", c[0] & c[1] & c[2], n);
    end
    $display("test interrupt done");
    maint_mode_sw_i <= 1'h1;
    for (int e = 0; e < 8; e++) begin
      r = $random(seed);
      equip_num_sw_i <= e[2:0];
      tw_power_sw_i <= r[0] | r[1];
      fake_reply_sw_i <= r[2];
      repeat (5) @(posedge core_clk_i);
      tw_connect_i <= 1'h1;
      connect_equipment_code_i <= {r[3] ? e[2:0] : r[6:4], r[15:7]};
      @(posedge core_clk_i);
      tw_connect_i <= 1'h0;
      tw_read_i <= r[16];
      tw_data_i <= r[17];
      tw_write_i <= r[18];
      repeat (3) @(posedge core_clk_i);
      m = (connect_equipment_code_i[11:9] == e[2:0]) && tw_power_sw_i;
      chk("tw selected", {m, m & r[16], 1'h1}, {tw_selected_o, type_in_lamp_o, maint_lamp_o});
      press_cnt(1, n);
      chk("end of record", m & r[16] & r[17], n);
      chk("fake reply", r[2] & tw_power_sw_i & (r[16] | r[18]), tw_reply_o);
    end
    tw_read_i <= 1'h0;
    tw_write_i <= 1'h0;
    $display("test typewriter done");
    r = $random(seed);
    p_upper_i <= r[14:0];
    press_cnt(2, n);
    chk("restart halt", 1'h1, cpu_halt_o);
    p_upper_i <= ~r[14:0];
    cpu_stopped_i <= 1'h1;
    n = 0;
    while (return_jump_o !== 1'h1 && n < 20) begin
      @(posedge core_clk_i);
      n++;
    end
    chk("jump seen", 2'h3, {return_jump_o, prog_stop_lamp_o});
    chk("store addr", r[14:0], return_store_addr_o);
    chk("jump addr", 15'h0000, return_jump_addr_o);
    cpu_stopped_i <= 1'h0;
    $display("test restart done");
    maint_mode_sw_i <= 1'h0;
    sys_active_sw_i <= 1'h1;
    n = 0;
    repeat (10) begin
      @(posedge core_clk_i);
      if (internal_master_clear_o === 1'h1 && outward_master_clear_o === 1'h1) n++;
    end
    chk("both clears", 5'h03, {n[3:0], sys_active_lamp_o});
    sys_active_sw_i <= 1'h0;
    lv <= 21'h0e_0000;
    repeat (8) @(posedge core_clk_i);
    chk("halt on off", 3'h4, {cpu_halt_o, sys_active_lamp_o, maint_lamp_o});
    chk("locked jumps", 3'h0, sel_jump_cond_o);
    $display("test system active done");
    end_sim();
  end
endmodule
`default_nettype wire
